// file: core/cmpc_pkg.sv
// Constants for the comparator digital control block
// Behaviour
// - Every comparator has its own pair of control registers.
// - comparator_on enables a comparator; clear means off and lowest power.
// - Raw result low when positive below negative, high when above.
// - result_bit is 1 when positive above negative; output_invert flips it.
// - Inversion equals swapping inputs and changes nothing else; here it also makes an off comparator's result read 1.
// - Result readable in result_bit and in the result mirror register.
// - Pin driven only with pin_output_enable, direction cleared, comparator on.
// - With pin_output_enable set, comparator output overrides the port latch.
// - Port-latch override follows pin_output_enable only, never comparator_on.
// - Internal result is registered once per instruction cycle.
// - Pin result is not held to the instruction cycle unless sync applies.
// - speed_select resets to 1 (normal); 0 is low power; writable anytime.
// - Enabled rising or falling output edge sets the flag; software clears.
// - With timer_sync_enable, output latched on timer clock falling edge.
package cmpc_pkg;
   // -------------------------------------------------------------------------
   // Sizes
   // -------------------------------------------------------------------------
   localparam int CMPC_NUM_DEF = 2;
   localparam int CMPC_INSTR_DIV_DEF = 4;
   localparam int CMPC_NUM_MAX = 8;
   localparam int CMPC_DIV_MAX = 256;

   // -------------------------------------------------------------------------
   // Register byte offsets
   // -------------------------------------------------------------------------
   localparam logic [7:0] CMPC_OFS_CTRL0 = 8'h00;
   localparam logic [7:0] CMPC_OFS_CTRL1 = 8'h04;
   localparam logic [7:0] CMPC_OFS_MIRROR = 8'h40;
   localparam logic [7:0] CMPC_OFS_STATUS = 8'h44;
   localparam logic [7:0] CMPC_OFS_MASK = 8'h48;

   // -------------------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------------------
   localparam int CMPC_B_ON = 7;
   localparam int CMPC_B_OUT = 6;
   localparam int CMPC_B_OE = 5;
   localparam int CMPC_B_POL = 4;
   localparam int CMPC_B_SP = 2;
   localparam int CMPC_B_HYS = 1;
   localparam int CMPC_B_SYNC = 0;
   localparam int CMPC_B_INTP = 7;
   localparam int CMPC_B_INTN = 6;

   // -------------------------------------------------------------------------
   // Reset values
   // -------------------------------------------------------------------------
   localparam logic CMPC_RST_ON = 1'h0;
   localparam logic CMPC_RST_OE = 1'h0;
   localparam logic CMPC_RST_POL = 1'h0;
   localparam logic CMPC_RST_SP = 1'h1;
   localparam logic CMPC_RST_HYS = 1'h0;
   localparam logic CMPC_RST_SYNC = 1'h0;
   localparam logic CMPC_RST_INTP = 1'h0;
   localparam logic CMPC_RST_INTN = 1'h0;
   localparam logic CMPC_RST_MASK = 1'h0;
endpackage

// file: core/cmpc_top.sv
// Comparator digital control: registers, result paths, pin drive, interrupt
//
// Chosen here: the Avalon-MM register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module cmpc_top #(
   parameter int NUM_CMP = cmpc_pkg::CMPC_NUM_DEF,
   parameter int INSTR_DIV = cmpc_pkg::CMPC_INSTR_DIV_DEF
) (
   input wire logic CLK_I,                          // 10 MHz clock
   input wire logic RST_N_I,                        // Sync reset, active low

   input wire logic [7:0] ADDRESS_I,                // Avalon byte address
   input wire logic READ_I,                         // Avalon read
   input wire logic WRITE_I,                        // Avalon write
   input wire logic [3:0] BYTEENABLE_I,             // Avalon byte enables
   input wire logic [31:0] WRITEDATA_I,             // Avalon write data
   output logic [31:0] READDATA_O,                  // Avalon read data
   output logic WAITREQUEST_O,                      // Avalon wait request

   input wire logic [NUM_CMP-1:0] CMP_RAW_I,        // Raw analog comparison
   input wire logic TMR_CLK_I,                      // Timer source clock
   input wire logic [NUM_CMP-1:0] PIN_DIR_I,        // Pin direction, 1 = input

   output logic [NUM_CMP-1:0] CMP_ON_O,             // Analog front end enable
   output logic [NUM_CMP-1:0] CMP_SPEED_O,          // 1 normal, 0 low power
   output logic [NUM_CMP-1:0] CMP_HYST_O,           // Hysteresis enable
   output logic [NUM_CMP-1:0] CMP_RESULT_O,         // Result to peripherals
   output logic [NUM_CMP-1:0] PIN_O,                // Pin output level
   output logic [NUM_CMP-1:0] PIN_OE_N_O,           // Pin drive, active low
   output logic [NUM_CMP-1:0] PORT_OVR_O,           // Port latch override
   output logic IRQ_O                               // Interrupt, level high
);
   // -------------------------------------------------------------------------
   // Parameter checks
   // -------------------------------------------------------------------------
   if (NUM_CMP < 1 || NUM_CMP > cmpc_pkg::CMPC_NUM_MAX) begin : g_chk_num
      $error("NUM_CMP out of range");
   end
   if (INSTR_DIV < 1 || INSTR_DIV > cmpc_pkg::CMPC_DIV_MAX) begin : g_chk_div
      $error("INSTR_DIV out of range");
   end
   // Control registers must stay clear of the shared registers
   if (NUM_CMP * 8 > 64) begin : g_chk_map
      $error("NUM_CMP overlaps the shared registers");
   end

   // -------------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic [NUM_CMP-1:0] raw_s1;
      logic [NUM_CMP-1:0] raw_s2;
      logic [NUM_CMP-1:0] raw_s3;
      logic [NUM_CMP-1:0] raw_val;

      logic tmr_s1;
      logic tmr_s2;
      logic tmr_s3;
      logic tmr_val;
      logic [NUM_CMP-1:0] sync_lat;

      logic [NUM_CMP-1:0] on;
      logic [NUM_CMP-1:0] oe;
      logic [NUM_CMP-1:0] pol;
      logic [NUM_CMP-1:0] sp;
      logic [NUM_CMP-1:0] hys;
      logic [NUM_CMP-1:0] syn;
      logic [NUM_CMP-1:0] intp;
      logic [NUM_CMP-1:0] intn;

      logic [NUM_CMP-1:0] res;
      logic [NUM_CMP-1:0] flag;
      logic [NUM_CMP-1:0] mask;

      logic [NUM_CMP-1:0] pin;
      logic [NUM_CMP-1:0] pin_oe_n;
      logic [NUM_CMP-1:0] ovr;

      logic [7:0] div;
      logic ack;
      logic [31:0] rdata;
      logic irq;
   } cmpc_state_t;

   cmpc_state_t state_reg;
   cmpc_state_t state_next;

   // -------------------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------------------
   // Control register of comparator idx; sel1 picks the second one
   function automatic logic ctrl_hit(input logic [7:0] a, input int idx, input logic sel1);
      logic [7:0] base;
      base = 8'(idx * 8) + (sel1 ? cmpc_pkg::CMPC_OFS_CTRL1 : cmpc_pkg::CMPC_OFS_CTRL0);
      return a == base;
   endfunction

   // An input change counts only once stages 2 and 3 agree
   function automatic logic settle(input logic s2, input logic s3, input logic held);
      logic v;
      v = held;
      if (s2 == s3) begin
         v = s2;
      end
      return v;
   endfunction

   // Readable first control byte; the result bit is read-only
   function automatic logic [7:0] ctrl0_word(input logic on, input logic out, input logic oe,
         input logic pol, input logic sp, input logic hys, input logic syn);
      logic [7:0] w;
      w = 8'h00;
      w[cmpc_pkg::CMPC_B_ON] = on;
      w[cmpc_pkg::CMPC_B_OUT] = out;
      w[cmpc_pkg::CMPC_B_OE] = oe;
      w[cmpc_pkg::CMPC_B_POL] = pol;
      w[cmpc_pkg::CMPC_B_SP] = sp;
      w[cmpc_pkg::CMPC_B_HYS] = hys;
      w[cmpc_pkg::CMPC_B_SYNC] = syn;
      return w;
   endfunction

   // Readable second control byte
   function automatic logic [7:0] ctrl1_word(input logic intp, input logic intn);
      logic [7:0] w;
      w = 8'h00;
      w[cmpc_pkg::CMPC_B_INTP] = intp;
      w[cmpc_pkg::CMPC_B_INTN] = intn;
      return w;
   endfunction

   // -------------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------------
   always_comb begin
      logic [NUM_CMP-1:0] cur;
      logic [NUM_CMP-1:0] sel;
      logic [NUM_CMP-1:0] set;
      logic [NUM_CMP-1:0] clr;
      logic [NUM_CMP-1:0] rise;
      logic [NUM_CMP-1:0] fall;
      logic tmr_fall;
      logic tick;

      cur = '0;
      sel = '0;
      set = '0;
      clr = '0;
      rise = '0;
      fall = '0;
      tmr_fall = 1'b0;
      tick = 1'b0;
      state_next = state_reg;

      // ----------------------------------------------------------------------
      // Synchronisers
      // ----------------------------------------------------------------------
      state_next.raw_s1 = CMP_RAW_I;
      state_next.raw_s2 = state_reg.raw_s1;
      state_next.raw_s3 = state_reg.raw_s2;
      for (int i = 0; i < NUM_CMP; i++) begin
         state_next.raw_val[i] = settle(state_reg.raw_s2[i], state_reg.raw_s3[i], state_reg.raw_val[i]);
      end
      state_next.tmr_s1 = TMR_CLK_I;
      state_next.tmr_s2 = state_reg.tmr_s1;
      state_next.tmr_s3 = state_reg.tmr_s2;
      state_next.tmr_val = settle(state_reg.tmr_s2, state_reg.tmr_s3, state_reg.tmr_val);
      tmr_fall = state_reg.tmr_val & ~state_next.tmr_val;

      // ----------------------------------------------------------------------
      // Result paths
      // ----------------------------------------------------------------------
      // Polarity before the split so pin and internal paths agree
      cur = (state_reg.on & state_reg.raw_val) ^ state_reg.pol;
      if (tmr_fall) begin
         state_next.sync_lat = cur;
      end
      for (int i = 0; i < NUM_CMP; i++) begin
         sel[i] = state_reg.syn[i] ? state_reg.sync_lat[i] : cur[i];
      end

      // ----------------------------------------------------------------------
      // Pin drive
      // ----------------------------------------------------------------------
      // Pin path follows every clock, not the instruction cycle
      state_next.pin = sel;
      state_next.pin_oe_n = ~(state_reg.oe & state_reg.on & ~PIN_DIR_I);
      state_next.ovr = state_reg.oe;

      // ----------------------------------------------------------------------
      // Instruction tick
      // ----------------------------------------------------------------------
      tick = state_reg.div == 8'(INSTR_DIV - 1);
      state_next.div = tick ? 8'h00 : state_reg.div + 8'h01;
      if (tick) begin
         state_next.res = sel;
         // Edges of the reported output, so polarity or on/off changes also count
         rise = sel & ~state_reg.res;
         fall = ~sel & state_reg.res;
         set = (rise & state_reg.intp) | (fall & state_reg.intn);
      end

      // ----------------------------------------------------------------------
      // Bus read
      // ----------------------------------------------------------------------
      // One wait cycle, answer on the next
      state_next.ack = (READ_I | WRITE_I) & ~state_reg.ack;

      if ((READ_I | WRITE_I) & ~state_reg.ack) begin
         state_next.rdata = '0;
         for (int i = 0; i < NUM_CMP; i++) begin
            if (ctrl_hit(ADDRESS_I, i, 1'b0)) begin
               state_next.rdata[7:0] = ctrl0_word(state_reg.on[i], state_reg.res[i], state_reg.oe[i],
                  state_reg.pol[i], state_reg.sp[i], state_reg.hys[i], state_reg.syn[i]);
            end
            if (ctrl_hit(ADDRESS_I, i, 1'b1)) begin
               state_next.rdata[7:0] = ctrl1_word(state_reg.intp[i], state_reg.intn[i]);
            end
         end
         if (ADDRESS_I == cmpc_pkg::CMPC_OFS_MIRROR) begin
            state_next.rdata[NUM_CMP-1:0] = state_reg.res;
         end
         if (ADDRESS_I == cmpc_pkg::CMPC_OFS_STATUS) begin
            state_next.rdata[NUM_CMP-1:0] = state_reg.flag;
         end
         if (ADDRESS_I == cmpc_pkg::CMPC_OFS_MASK) begin
            state_next.rdata[NUM_CMP-1:0] = state_reg.mask;
         end
      end

      // ----------------------------------------------------------------------
      // Bus write
      // ----------------------------------------------------------------------
      // Writes land on the edge where waitrequest is low
      if (state_reg.ack & WRITE_I & BYTEENABLE_I[0]) begin
         for (int i = 0; i < NUM_CMP; i++) begin
            if (ctrl_hit(ADDRESS_I, i, 1'b0)) begin
               state_next.on[i] = WRITEDATA_I[cmpc_pkg::CMPC_B_ON];
               state_next.oe[i] = WRITEDATA_I[cmpc_pkg::CMPC_B_OE];
               state_next.pol[i] = WRITEDATA_I[cmpc_pkg::CMPC_B_POL];
               state_next.sp[i] = WRITEDATA_I[cmpc_pkg::CMPC_B_SP];
               state_next.hys[i] = WRITEDATA_I[cmpc_pkg::CMPC_B_HYS];
               state_next.syn[i] = WRITEDATA_I[cmpc_pkg::CMPC_B_SYNC];
            end
            if (ctrl_hit(ADDRESS_I, i, 1'b1)) begin
               state_next.intp[i] = WRITEDATA_I[cmpc_pkg::CMPC_B_INTP];
               state_next.intn[i] = WRITEDATA_I[cmpc_pkg::CMPC_B_INTN];
            end
         end
         if (ADDRESS_I == cmpc_pkg::CMPC_OFS_MASK) begin
            state_next.mask = WRITEDATA_I[NUM_CMP-1:0];
         end
      end

      // ----------------------------------------------------------------------
      // Status flags
      // ----------------------------------------------------------------------
      // Read clears only what was reported, so a later edge is never lost
      if (state_reg.ack & READ_I & (ADDRESS_I == cmpc_pkg::CMPC_OFS_STATUS)) begin
         clr = state_reg.rdata[NUM_CMP-1:0];
      end
      state_next.flag = (state_reg.flag & ~clr) | set;
      state_next.irq = |(state_next.flag & state_next.mask);
   end

   // -------------------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------------------
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         state_reg <= '0;
         // Register fields take their reset values, the rest clears except pin_oe_n
         state_reg.on <= {NUM_CMP{cmpc_pkg::CMPC_RST_ON}};
         state_reg.oe <= {NUM_CMP{cmpc_pkg::CMPC_RST_OE}};
         state_reg.pol <= {NUM_CMP{cmpc_pkg::CMPC_RST_POL}};
         state_reg.sp <= {NUM_CMP{cmpc_pkg::CMPC_RST_SP}};
         state_reg.hys <= {NUM_CMP{cmpc_pkg::CMPC_RST_HYS}};
         state_reg.syn <= {NUM_CMP{cmpc_pkg::CMPC_RST_SYNC}};
         state_reg.intp <= {NUM_CMP{cmpc_pkg::CMPC_RST_INTP}};
         state_reg.intn <= {NUM_CMP{cmpc_pkg::CMPC_RST_INTN}};
         state_reg.mask <= {NUM_CMP{cmpc_pkg::CMPC_RST_MASK}};
         // Pin drivers start released
         state_reg.pin_oe_n <= '1;
      end else begin
         state_reg <= state_next;
      end
   end

   // -------------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------------
   // Every output comes from a flop, WAITREQUEST_O through an inverter
   assign READDATA_O = state_reg.rdata;
   assign WAITREQUEST_O = ~state_reg.ack;

   assign CMP_ON_O = state_reg.on;
   assign CMP_SPEED_O = state_reg.sp;
   assign CMP_HYST_O = state_reg.hys;
   assign CMP_RESULT_O = state_reg.res;

   assign PIN_O = state_reg.pin;
   assign PIN_OE_N_O = state_reg.pin_oe_n;
   assign PORT_OVR_O = state_reg.ovr;
   assign IRQ_O = state_reg.irq;
endmodule
`default_nettype wire

// file: bench/cmpc_top_asserts.sv
// Port assertions for the comparator control block
`timescale 1ns/10ps
`default_nettype none
module cmpc_top_asserts #(
   parameter int NUM_CMP = 2
) (
   input wire logic CLK_I, // Clock
   input wire logic RST_N_I, // Reset
   input wire logic READ_I, // Read
   input wire logic WRITE_I, // Write
   input wire logic WAITREQUEST_O, // Wait
   input wire logic [NUM_CMP-1:0] CMP_RAW_I, // Raw
   input wire logic [NUM_CMP-1:0] PIN_DIR_I, // Direction
   input wire logic [NUM_CMP-1:0] CMP_ON_O, // Enable
   input wire logic [NUM_CMP-1:0] CMP_SPEED_O, // Speed
   input wire logic [NUM_CMP-1:0] CMP_RESULT_O, // Result
   input wire logic [NUM_CMP-1:0] PIN_O, // Pin
   input wire logic [NUM_CMP-1:0] PIN_OE_N_O, // Drive
   input wire logic [NUM_CMP-1:0] PORT_OVR_O, // Override
   input wire logic IRQ_O // Interrupt
);
   logic wr_ack;
   logic [4:0] quiet_reg;
   assign wr_ack = WRITE_I && !WAITREQUEST_O;
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (!RST_N_I);
   // ---------------
   // Settling count
   // ---------------
   // Sync timing is long, so both paths are compared only when quiet
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I || WRITE_I || $changed(CMP_RAW_I)) begin
         quiet_reg <= 5'h00;
      end else if (quiet_reg != 5'h1F) begin
         quiet_reg <= quiet_reg + 5'h01;
      end
   end
   // ---------------
   // Properties
   // ---------------
   bus_answer_a: assert property ((READ_I || WRITE_I) && WAITREQUEST_O |=> !WAITREQUEST_O)
      else $error("request not answered in one cycle");
   bus_release_a: assert property (!WAITREQUEST_O |=> WAITREQUEST_O)
      else $error("wait request low too long");
   reset_vals_a: assert property ($rose(RST_N_I) |-> CMP_SPEED_O == '1 && PIN_OE_N_O == '1 && !IRQ_O)
      else $error("wrong value after reset");
   pin_dir_a: assert property ((~PIN_OE_N_O & $past(PIN_DIR_I)) == '0)
      else $error("pin driven while direction is input");
   pin_on_a: assert property ((~PIN_OE_N_O & ~CMP_ON_O & ~$past(CMP_ON_O)) == '0)
      else $error("pin driven while comparator off");
   paths_agree_a: assert property (quiet_reg == 5'h1F |-> ((CMP_RESULT_O ^ PIN_O) & ~PIN_OE_N_O) == '0)
      else $error("pin and internal result differ");
   result_tick_a: assert property ($changed(CMP_RESULT_O) |=> $stable(CMP_RESULT_O) [*3])
      else $error("result updated off the instruction tick");
   irq_fall_a: assert property ($fell(IRQ_O) |-> $past(!WAITREQUEST_O, 1) || $past(!WAITREQUEST_O, 2))
      else $error("interrupt dropped without bus access");
   irq_rise_a: assert property ($rose(IRQ_O) |-> CMP_RESULT_O != $past(CMP_RESULT_O, 2)
      || $past(wr_ack, 1) || $past(wr_ack, 2))
      else $error("interrupt without result edge");
   config_src_a: assert property ($changed(PORT_OVR_O) || $changed(CMP_SPEED_O)
      |-> $past(wr_ack, 1) || $past(wr_ack, 2))
      else $error("override or speed changed without write");
   cover property (IRQ_O);
   cover property (!PIN_OE_N_O[0]);
   cover property (quiet_reg == 5'h1F && CMP_RESULT_O != '0);
endmodule
`default_nettype wire

// file: bench/cmpc_front.sv
// Analog comparator front end model
`timescale 1ns/10ps
`default_nettype none
module cmpc_front #(
   parameter int NUM_CMP = 2
) (
   input wire logic clk_i, // Clock
   input wire logic [NUM_CMP-1:0] on_i, // Enable
   input wire logic [NUM_CMP-1:0] speed_i, // 1 normal
   input wire logic [NUM_CMP*8-1:0] pos_i, // Positive levels
   input wire logic [NUM_CMP*8-1:0] neg_i, // Negative levels
   output logic [NUM_CMP-1:0] raw_o, // Raw result
   output logic tmr_clk_o // Timer clock
);
   logic [NUM_CMP-1:0] d1 = '0;
   logic [NUM_CMP-1:0] d2 = '0;
   int tc = 0;
   initial raw_o = '0;
   initial tmr_clk_o = 1'b0;
   always @(posedge clk_i) begin
      tc <= (tc == 2) ? 0 : tc + 1;
      if (tc == 2) tmr_clk_o <= ~tmr_clk_o;
      for (int i = 0; i < NUM_CMP; i++) begin
         d1[i] <= pos_i[i*8+:8] > neg_i[i*8+:8];
         d2[i] <= d1[i];
         // Off front end gives no meaningful level
         if (!on_i[i]) raw_o[i] <= ~raw_o[i];
         else raw_o[i] <= speed_i[i] ? d1[i] : d2[i];
      end
   end
endmodule
`default_nettype wire

// file: bench/cmpc_top_tb.sv
// Self-checking bench for the comparator control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fail_count++; \
   $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module cmpc_top_tb;
   localparam int N = 2;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic [31:0] q;
   logic [N-1:0] dir = '1;
   logic [N*8-1:0] pos = '0;
   logic [N*8-1:0] neg = '0;
   logic [7:0] ctl [N];
   logic [N-1:0] expv, oen, eon, esp, ehy, eov;
   int fail_count = 0;
   int total_checks = 0;
   wire logic [31:0] rdat;
   wire logic wreq, tmr, irq;
   wire logic [N-1:0] raw, on, spd, hys, res, pin, pin_oe_n, ovr;
   cmpc_top #(.NUM_CMP(N)) u_dut (.CLK_I(clk), .RST_N_I(rst_n), .ADDRESS_I(addr), .READ_I(rd),
      .WRITE_I(wr), .BYTEENABLE_I(4'h1), .WRITEDATA_I(wdata), .READDATA_O(rdat), .WAITREQUEST_O(wreq),
      .CMP_RAW_I(raw), .TMR_CLK_I(tmr), .PIN_DIR_I(dir), .CMP_ON_O(on), .CMP_SPEED_O(spd),
      .CMP_HYST_O(hys), .CMP_RESULT_O(res), .PIN_O(pin), .PIN_OE_N_O(pin_oe_n), .PORT_OVR_O(ovr), .IRQ_O(irq));
   cmpc_front #(.NUM_CMP(N)) u_front (.clk_i(clk), .on_i(on), .speed_i(spd), .pos_i(pos), .neg_i(neg),
      .raw_o(raw), .tmr_clk_o(tmr));
   always #50 clk = ~clk;
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      rd <= !w;
      wr <= w;
      addr <= a;
      wdata <= d;
      do begin
         @(posedge clk);
         n++;
      end while (wreq !== 1'b0 && n < 50);
      if (wreq !== 1'b0) fail_count++;
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   function automatic logic exp_res(int j);
      logic gt;
      gt = pos[j*8+:8] > neg[j*8+:8];
      return ctl[j][7] ? gt ^ ctl[j][4] : ctl[j][4];
   endfunction
   task automatic check_all();
      for (int j = 0; j < N; j++) begin
         expv[j] = exp_res(j);
         oen[j] = !(ctl[j][5] && ctl[j][7] && !dir[j]);
         {eon[j], eov[j], esp[j], ehy[j]} = {ctl[j][7], ctl[j][5], ctl[j][2], ctl[j][1]};
         bus(1'b0, 8'(8 * j), 32'h0000_0000);
         `CHK(q, {24'h00_0000, ctl[j] | 8'(expv[j]) << 6})
      end
      bus(1'b0, 8'h40, 32'h0000_0000);
      `CHK(q, 32'(expv))
      `CHK(res, expv)
      `CHK({on, spd, hys, ovr}, {eon, esp, ehy, eov})
      `CHK(pin_oe_n, oen)
      `CHK(pin & ~oen, expv & ~oen)
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      int i;
      logic [7:0] p;
      q = $urandom(81);
      foreach (ctl[j]) ctl[j] = 8'h04;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      bus(1'b0, 8'h80, 32'h0000_0000);
      `CHK(q, 32'h0000_0000)
      check_all();
      $display("test reset_state done");
      for (int k = 0; k < 24; k++) begin
         i = $urandom_range(N - 1);
         ctl[i] = 8'($urandom) & 8'hB7;
         // Corners: on and inverted, off with drive asked, low power
         if (k < 3) ctl[i] = k == 0 ? 8'hB4 : k == 1 ? 8'h30 : 8'hA0;
         p = 8'($urandom);
         pos[i*8+:8] <= p;
         neg[i*8+:8] <= p ^ (8'h01 << $urandom_range(7));
         dir[i] <= k < 3 ? 1'b0 : 1'($urandom);
         bus(1'b1, 8'(8 * i), {24'h00_0000, ctl[i] | 8'h40});
         repeat (40) @(posedge clk);
         check_all();
      end
      $display("test random_config done");
      ctl[0] = 8'h84;
      pos[7:0] <= 8'h10;
      neg[7:0] <= 8'h80;
      bus(1'b1, 8'h00, 32'h0000_0084);
      bus(1'b1, 8'h04, 32'h0000_00C0);
      bus(1'b1, 8'h48, 32'h0000_0001);
      repeat (40) @(posedge clk);
      bus(1'b0, 8'h44, 32'h0000_0000);
      repeat (4) @(posedge clk);
      `CHK(irq, 1'b0)
      pos[7:0] <= 8'hF0;
      repeat (40) @(posedge clk);
      `CHK(irq, 1'b1)
      bus(1'b0, 8'h44, 32'h0000_0000);
      `CHK(q, 32'h0000_0001)
      repeat (4) @(posedge clk);
      `CHK(irq, 1'b0)
      bus(1'b1, 8'h48, 32'h0000_0000);
      pos[7:0] <= 8'h10;
      repeat (40) @(posedge clk);
      `CHK(irq, 1'b0)
      bus(1'b0, 8'h44, 32'h0000_0000);
      `CHK(q, 32'h0000_0001)
      $display("test interrupt done");
      results();
   end
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      results();
   end
endmodule
bind cmpc_top cmpc_top_asserts #(.NUM_CMP(NUM_CMP)) u_chk (.CLK_I, .RST_N_I, .READ_I, .WRITE_I,
   .WAITREQUEST_O, .CMP_RAW_I, .PIN_DIR_I, .CMP_ON_O, .CMP_SPEED_O, .CMP_RESULT_O, .PIN_O,
   .PIN_OE_N_O, .PORT_OVR_O, .IRQ_O);
`default_nettype wire
